// *** core/sync_slave_pkg.sv ***
// Constants and register map of the synchronous slave serial port.
//
// Contract
// R1: With two words queued at sleep, the first moves to the shifter and transmits.
// R2: The second word waits in the holding register; tx_empty_flag stays clear.
// R3: After the first word leaves, load the pending word, then set tx_empty_flag.
// R4: Transmit interrupt with peripheral enable wakes core; global enable adds vectoring.
// R5: Software sets sync, port enable, slave clock, clears receive enables, then tx_enable.
// R6: In nine-bit transmit the ninth bit is set first and sent with the word.
// R7: Writing the holding register starts transmission, clocked by the external master.
// R8: Continuous receive stays set in slave receive, so the receiver never idles.
// R9: Single receive enable has no effect on slave reception.
// R10: A character received during sleep moves to the buffer and may wake the core.
// R11: After wake the core resumes; with global enable it calls the fixed vector.
// R12: Only synchronous slave mode runs its shifters during sleep.
// R13: Both shifters are clocked by the serial clock from the external master.
// R14: Software sets sync, port enable, slave clock, nine-bit option, then continuous receive.
// R15: A complete character sets rx_full_flag and requests an interrupt when enabled.
// R16: Software reads the ninth received bit before the low eight data bits.
// R17: Overrun clears when continuous receive or port enable is cleared.
// R18: Reading the receive buffer drains it; rx_full_flag clears once empty.
// R19: While the core sleeps the port still accepts clock and data from the master.
// R20: Filling shifter and holding register before sleep leaves tx_empty_flag clear.
// R21: Writing a new character after a sleep transfer clears tx_empty_flag again.
// R22: Software enables transmit and peripheral interrupts before sleep to get a wake.
// R23: Data changes on the leading edge, valid at trailing edge; one clock per bit.
// R24: In slave mode the clock pin driver is off; the pin is an input only.
// R25: Two-character receive buffer; a third sets overrun, keeps data, stops reception.
// R26: Received data is sampled on the trailing serial clock edge.
// R27: Serial clock edges are synchronised into the system clock before use.
package sync_slave_pkg;
   localparam int         ADDR_W     = 5;
   localparam int         DATA_W     = 32;
   localparam logic [4:0] TCS_OFF    = 5'h00;
   localparam logic [4:0] RCS_OFF    = 5'h04;
   localparam logic [4:0] BAUD_OFF   = 5'h08;
   localparam logic [4:0] THD_OFF    = 5'h0c;
   localparam logic [4:0] RBD_OFF    = 5'h10;
   localparam logic [4:0] IRQC_OFF   = 5'h14;
   localparam logic [4:0] IRQF_OFF   = 5'h18;
   localparam int         TCS_MASTER = 7;
   localparam int         TCS_NINE   = 6;
   localparam int         TCS_TX_ENABLE   = 5;
   localparam int         TCS_SYNC   = 4;
   localparam int         TCS_EMPTY  = 1;
   localparam int         TCS_NINTH  = 0;
   localparam int         RCS_PEN    = 7;
   localparam int         RCS_NINE   = 6;
   localparam int         RCS_SINGLE = 5;
   localparam int         RCS_CONT   = 4;
   localparam int         RCS_OVR    = 1;
   localparam int         RCS_NINTH  = 0;
   localparam int         BAUD_IDLE  = 6;
   localparam int         BAUD_INV   = 4;
   localparam int         IRQ_GLOBAL = 3;
   localparam int         IRQ_PERIPH = 2;
   localparam int         IRQ_RX     = 1;
   localparam int         IRQ_TX     = 0;
   localparam int         FLG_RX     = 1;
   localparam int         FLG_TX     = 0;
   localparam logic [3:0] BITS_8     = 4'h8;
   localparam logic [3:0] BITS_9     = 4'h9;
   localparam logic [1:0] RX_FULL    = 2'h2;
   localparam int         RX_DEPTH   = 2;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_ERR   = 2'h2;
   localparam logic [11:0] VECTOR_ADDR = 12'h004;
endpackage

// *** core/sync_slave_serial_port.sv ***
// Synchronous slave serial port with an AXI4-Lite register slave.
`timescale 1ns/10ps
module sync_slave_serial_port
(
   input  wire logic                              ref_clk,
   input  wire logic                              rst,
   input  wire logic [sync_slave_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                              awvalid,
   output logic                                   awready,
   input  wire logic [sync_slave_pkg::DATA_W-1:0] wdata,
   input  wire logic [3:0]                        wstrb,
   input  wire logic                              wvalid,
   output logic                                   wready,
   output logic [1:0]                             bresp,
   output logic                                   bvalid,
   input  wire logic                              bready,
   input  wire logic [sync_slave_pkg::ADDR_W-1:0] araddr,
   input  wire logic                              arvalid,
   output logic                                   arready,
   output logic [sync_slave_pkg::DATA_W-1:0]      rdata,
   output logic [1:0]                             rresp,
   output logic                                   rvalid,
   input  wire logic                              rready,
   input  wire logic                              core_sleep,
   input  wire logic                              clock_pin_in,
   output logic                                   clock_pin_out,
   output logic                                   clock_pin_oe_n,
   input  wire logic                              data_pin_in,
   output logic                                   data_pin_out,
   output logic                                   data_pin_oe_n,
   output logic                                   irq_request,
   output logic                                   wake_core,
   output logic                                   vector_call,
   output logic [11:0]                            vector_address
);
   import sync_slave_pkg::*;

   logic                clock_source_master;
   logic                nine_bit_tx_select;
   logic                tx_enable;
   logic                sync_mode;
   logic                ninth_tx_bit;
   logic                port_enable;
   logic                nine_bit_rx_select;
   logic                single_rx_enable;
   logic                continuous_rx_enable;
   logic                clock_invert;
   logic                global_irq_enable;
   logic                peripheral_irq_enable;
   logic                rx_irq_enable;
   logic                tx_irq_enable;
   logic                aw_held;
   logic                w_held;
   logic [ADDR_W-1:0]   wr_addr;
   logic [7:0]          wr_data;
   logic                wr_low;
   logic                wr_fire;
   logic                wr_hit;
   logic                rd_fire;
   logic                rd_hit;
   logic [7:0]          rd_byte;
   logic                ck_s1;
   logic                ck_s2;
   logic                ck_d;
   logic                dt_s1;
   logic                dt_s2;
   logic                lead_edge;
   logic                trail_edge;
   logic                slave;
   logic                tx_run;
   logic                rx_run;
   logic [8:0]          hold_data;
   logic                hold_valid;
   logic [8:0]          transmit_shifter;
   logic [3:0]          tx_left;
   logic                tx_busy;
   logic                tx_load;
   logic                thd_write;
   logic                tx_empty_flag;
   logic [8:0]          receive_shifter;
   logic [3:0]          rx_got;
   logic [3:0]          rx_bits;
   logic [8:0]          rx_new;
   logic [8:0]          rx_word;
   logic                rx_sample;
   logic                rx_done;
   logic                rx_push;
   logic                rx_pop;
   logic [8:0]          rx_mem [RX_DEPTH];
   logic [1:0]          rx_count;
   logic                rx_head;
   logic                rx_tail;
   logic                rx_full_flag;
   logic                overrun_flag;
   logic                pending;

   // Bus slave: address and data are taken in either order, the write acts once both
   // are held, and each channel reopens only after the response has been taken.
   assign wr_fire = aw_held && w_held && !bvalid;
   assign rd_fire = arvalid && arready;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         aw_held <= 1'b0;
         awready <= 1'b0;
         wr_addr <= '0;
      end
      else if (awvalid && awready)
      begin
         aw_held <= 1'b1;
         awready <= 1'b0;
         wr_addr <= awaddr;
      end
      else
      begin
         if (wr_fire)
            aw_held <= 1'b0;
         if (!aw_held && !bvalid)
            awready <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         w_held  <= 1'b0;
         wready  <= 1'b0;
         wr_data <= '0;
         wr_low  <= 1'b0;
      end
      else if (wvalid && wready)
      begin
         w_held  <= 1'b1;
         wready  <= 1'b0;
         wr_data <= wdata[7:0];
         wr_low  <= wstrb[0];
      end
      else
      begin
         if (wr_fire)
            w_held <= 1'b0;
         if (!w_held && !bvalid)
            wready <= 1'b1;
      end
   end

   always_comb
   begin
      unique case (wr_addr)
         TCS_OFF, RCS_OFF, BAUD_OFF, THD_OFF, RBD_OFF, IRQC_OFF, IRQF_OFF: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid <= 1'b1;
         bresp  <= wr_hit ? RESP_OKAY : RESP_ERR;
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   assign thd_write = wr_fire && wr_low && (wr_addr == THD_OFF);

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         clock_source_master   <= 1'b0;
         nine_bit_tx_select    <= 1'b0;
         tx_enable             <= 1'b0;
         sync_mode             <= 1'b0;
         ninth_tx_bit          <= 1'b0;
         port_enable           <= 1'b0;
         nine_bit_rx_select    <= 1'b0;
         single_rx_enable      <= 1'b0;
         continuous_rx_enable  <= 1'b0;
         clock_invert          <= 1'b0;
         global_irq_enable     <= 1'b0;
         peripheral_irq_enable <= 1'b0;
         rx_irq_enable         <= 1'b0;
         tx_irq_enable         <= 1'b0;
      end
      else if (wr_fire && wr_low)
      begin
         if (wr_addr == TCS_OFF)
         begin
            clock_source_master <= wr_data[TCS_MASTER];
            nine_bit_tx_select  <= wr_data[TCS_NINE];
            tx_enable           <= wr_data[TCS_TX_ENABLE];
            sync_mode           <= wr_data[TCS_SYNC];
            ninth_tx_bit        <= wr_data[TCS_NINTH];
         end
         if (wr_addr == RCS_OFF)
         begin
            port_enable          <= wr_data[RCS_PEN];
            nine_bit_rx_select   <= wr_data[RCS_NINE];
            single_rx_enable     <= wr_data[RCS_SINGLE];
            continuous_rx_enable <= wr_data[RCS_CONT];
         end
         if (wr_addr == BAUD_OFF)
            clock_invert <= wr_data[BAUD_INV];
         if (wr_addr == IRQC_OFF)
         begin
            global_irq_enable     <= wr_data[IRQ_GLOBAL];
            peripheral_irq_enable <= wr_data[IRQ_PERIPH];
            rx_irq_enable         <= wr_data[IRQ_RX];
            tx_irq_enable         <= wr_data[IRQ_TX];
         end
      end
   end

   // The ninth bit shown is that of the oldest unread character, so it must be read
   // before the data register pops it.
   always_comb
   begin
      rd_byte = 8'h00;
      rd_hit  = 1'b1;
      unique case (araddr)
         TCS_OFF:
         begin
            rd_byte[TCS_MASTER] = clock_source_master;
            rd_byte[TCS_NINE]   = nine_bit_tx_select;
            rd_byte[TCS_TX_ENABLE]   = tx_enable;
            rd_byte[TCS_SYNC]   = sync_mode;
            rd_byte[TCS_EMPTY]  = !tx_busy;
            rd_byte[TCS_NINTH]  = ninth_tx_bit;
         end
         RCS_OFF:
         begin
            rd_byte[RCS_PEN]    = port_enable;
            rd_byte[RCS_NINE]   = nine_bit_rx_select;
            rd_byte[RCS_SINGLE] = single_rx_enable;
            rd_byte[RCS_CONT]   = continuous_rx_enable;
            rd_byte[RCS_OVR]    = overrun_flag;
            rd_byte[RCS_NINTH]  = rx_mem[rx_head][8]; // see R16
         end
         BAUD_OFF:
         begin
            rd_byte[BAUD_IDLE] = !rx_run;
            rd_byte[BAUD_INV]  = clock_invert;
         end
         RBD_OFF:
            rd_byte = rx_mem[rx_head][7:0];
         IRQC_OFF:
         begin
            rd_byte[IRQ_GLOBAL] = global_irq_enable;
            rd_byte[IRQ_PERIPH] = peripheral_irq_enable;
            rd_byte[IRQ_RX]     = rx_irq_enable;
            rd_byte[IRQ_TX]     = tx_irq_enable;
         end
         IRQF_OFF:
         begin
            rd_byte[FLG_RX] = rx_full_flag;
            rd_byte[FLG_TX] = tx_empty_flag;
         end
         THD_OFF:
            rd_byte = 8'h00;
         default:
            rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end
      else if (rd_fire)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= {24'h000000, rd_byte};
         rresp   <= rd_hit ? RESP_OKAY : RESP_ERR;
      end
      else
      begin
         if (rvalid && rready)
            rvalid <= 1'b0;
         if (!rvalid)
            arready <= 1'b1;
      end
   end

   // The master's clock is slow against ref_clk, so it is sampled and its edges found
   // here; the port keeps working while the core sleeps because ref_clk keeps running.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ck_s1 <= 1'b0;
         ck_s2 <= 1'b0;
         ck_d  <= 1'b0;
         dt_s1 <= 1'b0;
         dt_s2 <= 1'b0;
      end
      else
      begin
         ck_s1 <= clock_pin_in; // see R27
         ck_s2 <= ck_s1;
         ck_d  <= ck_s2;
         dt_s1 <= data_pin_in;
         dt_s2 <= dt_s1;
      end
   end

   assign lead_edge  = clock_invert ? (!ck_s2 && ck_d) : (ck_s2 && !ck_d); // see R13
   assign trail_edge = clock_invert ? (ck_s2 && !ck_d) : (!ck_s2 && ck_d); // see R13

   // Sleep does not gate the shifters: only the slave configuration runs them.
   assign slave  = port_enable && sync_mode && !clock_source_master; // see R12, R19
   assign tx_run = slave && !continuous_rx_enable && tx_enable;
   assign rx_run = slave && continuous_rx_enable; // see R8, R9

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         clock_pin_out  <= 1'b0;
         clock_pin_oe_n <= 1'b1;
         data_pin_oe_n  <= 1'b1;
      end
      else
      begin
         clock_pin_out  <= 1'b0;
         clock_pin_oe_n <= 1'b1; // see R24
         data_pin_oe_n  <= !tx_run;
      end
   end

   assign tx_load       = tx_run && hold_valid && !tx_busy; // see R1, R3
   assign tx_empty_flag = !hold_valid; // see R2, R20

   // A write to a full holding register is dropped rather than overwriting the word.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         hold_valid <= 1'b0;
         hold_data  <= '0;
      end
      else if (!port_enable)
         hold_valid <= 1'b0;
      else if (thd_write && !hold_valid)
      begin
         hold_valid <= 1'b1; // see R7, R21
         hold_data  <= {ninth_tx_bit, wr_data}; // see R6
      end
      else if (tx_load)
         hold_valid <= 1'b0; // see R3
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         transmit_shifter <= '0;
         tx_left          <= 4'h0;
         tx_busy          <= 1'b0;
         data_pin_out     <= 1'b0;
      end
      else if (!port_enable)
      begin
         tx_busy <= 1'b0;
         tx_left <= 4'h0;
      end
      else if (tx_load)
      begin
         transmit_shifter <= hold_data; // see R1
         tx_left          <= nine_bit_tx_select ? BITS_9 : BITS_8;
         tx_busy          <= 1'b1;
      end
      else if (tx_busy && tx_run && lead_edge && tx_left != 4'h0)
      begin
         data_pin_out     <= transmit_shifter[0]; // see R23
         transmit_shifter <= transmit_shifter >> 1;
         tx_left          <= tx_left - 4'h1;
      end
      else if (tx_busy && tx_run && trail_edge && tx_left == 4'h0)
         tx_busy <= 1'b0; // see R3
   end

   assign rx_bits   = nine_bit_rx_select ? BITS_9 : BITS_8;
   assign rx_new    = {dt_s2, receive_shifter[8:1]};
   assign rx_word   = nine_bit_rx_select ? rx_new : {1'b0, rx_new[8:1]};
   assign rx_sample = rx_run && trail_edge && !overrun_flag; // see R26, R25
   assign rx_done   = rx_sample && (rx_got == rx_bits - 4'h1);
   assign rx_push   = rx_done && (rx_count != RX_FULL); // see R10, R15
   assign rx_pop    = rd_fire && (araddr == RBD_OFF) && (rx_count != 2'h0); // see R18
   assign rx_tail   = rx_head ^ rx_count[0];

   // Dropping continuous receive discards a partial character.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         receive_shifter <= '0;
         rx_got          <= 4'h0;
      end
      else if (!rx_run)
         rx_got <= 4'h0;
      else if (rx_sample)
      begin
         receive_shifter <= rx_new; // see R26
         rx_got          <= rx_done ? 4'h0 : rx_got + 4'h1;
      end
   end

   for (genvar i = 0; i < RX_DEPTH; i++)
   begin : g_rx_entry
      always_ff @(posedge ref_clk or posedge rst)
      begin
         if (rst)
            rx_mem[i] <= '0;
         else if (rx_push && rx_tail == 1'(i))
            rx_mem[i] <= rx_word;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rx_count <= 2'h0;
         rx_head  <= 1'b0;
      end
      else if (!port_enable)
      begin
         rx_count <= 2'h0;
         rx_head  <= 1'b0;
      end
      else
      begin
         rx_count <= rx_count + {1'b0, rx_push} - {1'b0, rx_pop};
         if (rx_pop)
            rx_head <= !rx_head;
      end
   end

   assign rx_full_flag = rx_count != 2'h0; // see R15, R18

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         overrun_flag <= 1'b0;
      else if (!continuous_rx_enable || !port_enable)
         overrun_flag <= 1'b0; // see R17
      else if (rx_done && rx_count == RX_FULL)
         overrun_flag <= 1'b1; // see R25
   end

   assign pending = peripheral_irq_enable
                    && ((tx_empty_flag && tx_irq_enable) || (rx_full_flag && rx_irq_enable));

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         irq_request    <= 1'b0;
         wake_core      <= 1'b0;
         vector_call    <= 1'b0;
         vector_address <= 12'h000;
      end
      else
      begin
         irq_request    <= pending; // see R15
         wake_core      <= core_sleep && pending; // see R4, R10
         vector_call    <= pending && global_irq_enable; // see R11
         vector_address <= VECTOR_ADDR;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence s_tx_load;
      tx_run && hold_valid && !tx_busy;
   endsequence

   sequence s_word_out;
      tx_busy && tx_run && trail_edge && tx_left == 4'h0 && hold_valid;
   endsequence

   property p_first_word_moves;
      s_tx_load |=> tx_busy && !hold_valid && tx_empty_flag;
   endproperty
   a_first_word_moves: assert property (p_first_word_moves) // see R1
      else $error("holding word not moved to shifter");

   // The waiting word must stay put until the shifter frees, not merely hide the flag.
   property p_flag_waits;
      hold_valid && tx_busy && port_enable |=> hold_valid && !tx_empty_flag;
   endproperty
   a_flag_waits: assert property (p_flag_waits) // see R2
      else $error("empty flag set while word waits");

   property p_reload_after_word;
      s_word_out ##1 s_tx_load |=> tx_busy && tx_empty_flag;
   endproperty
   a_reload_after_word: assert property (p_reload_after_word) // see R3
      else $error("pending word not reloaded after shift out");

   property p_wake_tx;
      core_sleep && tx_empty_flag && tx_irq_enable && peripheral_irq_enable |=> wake_core;
   endproperty
   a_wake_tx: assert property (p_wake_tx) // see R4
      else $error("transmit empty did not wake core");

   property p_vector;
      wake_core && $past(global_irq_enable) |-> vector_call && vector_address == VECTOR_ADDR;
   endproperty
   a_vector: assert property (p_vector) // see R11
      else $error("wake without vector call");

   property p_write_clears;
      thd_write && !hold_valid && port_enable |=> !tx_empty_flag;
   endproperty
   a_write_clears: assert property (p_write_clears) // see R21
      else $error("holding write left empty flag set");

   property p_clock_input_only;
      !clock_pin_oe_n |-> 1'b0;
   endproperty
   a_clock_input_only: assert property (p_clock_input_only) // see R24
      else $error("clock pin driven");

   property p_overrun_holds;
      overrun_flag && port_enable && !rx_pop |=> rx_count == $past(rx_count);
   endproperty
   a_overrun_holds: assert property (p_overrun_holds) // see R25
      else $error("buffer changed during overrun");

   property p_overrun_clear;
      !continuous_rx_enable |=> !overrun_flag;
   endproperty
   a_overrun_clear: assert property (p_overrun_clear) // see R17
      else $error("overrun not cleared");

   property p_rx_complete;
      rx_done && rx_count == 2'h0
         |=> rx_full_flag ##1 (irq_request || !(rx_irq_enable && peripheral_irq_enable));
   endproperty
   a_rx_complete: assert property (p_rx_complete) // see R15
      else $error("complete character not flagged");
endmodule

// *** tb/link_master.sv ***
// Behavioural serial master driving the link clock.
`timescale 1ns/10ps
module link_master
(
   output logic      sck = 1'b0,
   output logic      sdo = 1'b1,
   input  wire logic sdi
);
   // The clock settles at its idle level first and then toggles off the system clock
   // edge, so the slave's synchroniser never races the pin.
   task automatic frame(input logic [8:0] d, output logic [8:0] q, input int nb = 8,
                        input logic pol = 1'b0);
      q = '0;
      sck = pol;
      #90;
      for (int i = 0; i < nb; i++)
      begin
         sck = !pol;
         sdo = d[i];
         #240;
         sck = pol;
         q[i] = sdi;
         #80;
      end
      sdo = ~sdo;
   endtask
endmodule

// *** tb/test_sync_slave_serial_port.sv ***
// Bench for the sync slave serial port.
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
   $display("wrong value at %0t: %h %h", $time, (a), (e)); end end
module test_sync_slave_serial_port;
   import sync_slave_pkg::*;
   logic        ref_clk, rst, awvalid, wvalid, bready, arvalid, rready, core_sleep, awready;
   logic        wready, bvalid, arready, rvalid, clock_pin_in, data_pin_in, clock_pin_out;
   logic        clock_pin_oe_n, data_pin_out, data_pin_oe_n, irq_request, wake_core, vector_call;
   logic [1:0]  bresp, rresp;
   logic [3:0]  wstrb;
   logic [4:0]  awaddr, araddr;
   logic [8:0]  q;
   logic [11:0] vector_address;
   logic [31:0] wdata, rdata;
   int          failures = 0, n_compared = 0, n;
   wire         dt_line = data_pin_oe_n ? data_pin_in : data_pin_out;
   sync_slave_serial_port i_sync_slave_serial_port (.*);
   link_master i_link_master (.sck(clock_pin_in), .sdo(data_pin_in), .sdi(dt_line));
   always #20 ref_clk = ~ref_clk;
   task end_sim;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // An exhausted wait counts as a mismatch and ends the run.
   task hang;
      failures += int'(n >= 60);
      if (n >= 60) end_sim;
   endtask
   task wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
      @(posedge ref_clk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, 24'h0, d, 3'b111};
      for (n = 0; n < 60 && bvalid !== 1'b1; n++)
         @(posedge ref_clk) {awvalid, wvalid} <= {awvalid && !awready, wvalid && !wready};
      hang;
      bready <= 1'b0;
      `CHK(bresp, r)
   endtask
   task rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
      @(posedge ref_clk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      for (n = 0; n < 60 && rvalid !== 1'b1; n++)
         @(posedge ref_clk) arvalid <= arvalid && !arready;
      hang;
      rready <= 1'b0;
      `CHK(rdata, e)
      `CHK(rresp, r)
   endtask
   task t_tx;
      wr(RCS_OFF, 8'h80);
      wr(TCS_OFF, 8'h30);
      wr(IRQC_OFF, 8'h05);
      wr(THD_OFF, 8'ha5);
      wr(THD_OFF, 8'h3c);
      rd(IRQF_OFF, 32'h0);
      core_sleep <= 1'b1;
      i_link_master.frame(9'h000, q);
      `CHK(q, 9'h0a5)
      for (n = 0; n < 60 && irq_request !== 1'b1; n++)
         @(posedge ref_clk);
      hang;
      `CHK(wake_core, 1'b1)
      wr(IRQC_OFF, 8'h0d);
      rd(IRQF_OFF, 32'h1);
      `CHK(vector_call, 1'b1)
      wr(THD_OFF, 8'h77);
      rd(IRQF_OFF, 32'h0);
      i_link_master.frame(9'h000, q);
      `CHK(q, 9'h03c)
      $display("transmit test done");
   endtask
   task t_rx;
      // Dropping the port first empties the transmit side left busy by the last test.
      wr(RCS_OFF, 8'h00);
      wr(RCS_OFF, 8'hb0);
      wr(IRQC_OFF, 8'h06);
      i_link_master.frame(9'h05a, q);
      for (n = 0; n < 60 && irq_request !== 1'b1; n++)
         @(posedge ref_clk);
      hang;
      `CHK(wake_core, 1'b1)
      i_link_master.frame(9'h0c3, q);
      i_link_master.frame(9'h011, q);
      repeat (4) @(posedge ref_clk);
      rd(RCS_OFF, 32'hb2);
      rd(RBD_OFF, 32'h5a);
      rd(RBD_OFF, 32'hc3);
      rd(IRQF_OFF, 32'h1);
      wr(RCS_OFF, 8'ha0);
      rd(RCS_OFF, 32'ha0);
      $display("receive test done");
   endtask
   task t_nine;
      wr(BAUD_OFF, 8'h10);
      wr(RCS_OFF, 8'h80);
      wr(TCS_OFF, 8'h71);
      wr(THD_OFF, 8'h96);
      i_link_master.frame(9'h000, q, 9, 1'b1);
      `CHK(q, 9'h196)
      wr(TCS_OFF, 8'h10);
      wr(RCS_OFF, 8'hd0);
      i_link_master.frame(9'h14b, q, 9, 1'b1);
      repeat (4) @(posedge ref_clk);
      rd(RCS_OFF, 32'hd1);
      rd(RBD_OFF, 32'h4b);
      $display("nine bit test done");
   endtask
   initial
   begin
      {ref_clk, rst, awvalid, wvalid, bready, arvalid, rready, core_sleep} = 8'h40;
      {awaddr, araddr, wdata, wstrb} = {42'h0, 4'hf};
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      rd(5'h1c, 32'h0, RESP_ERR);
      wr(5'h1c, 8'hff, RESP_ERR);
      `CHK(clock_pin_oe_n, 1'b1)
      `CHK(clock_pin_out, 1'b0)
      `CHK(vector_address, VECTOR_ADDR)
      t_tx;
      t_rx;
      t_nine;
      end_sim;
   end
endmodule
